// ---- design/lpc_legacy_range_decoder.v ----
// legacy range decoder: config registers plus registered address match for host cycles
// assumes host cycle strobes and config strobes come from logic on clk_sys;
// forward enables and the positive decode switch are driven from elsewhere on clk_sys
//
// Function
// - serial register bits 2:0 pick the first serial port window, 000 at 3F8h and 001 at 2F8h.
// - serial register bits 6:4 pick the second serial port window from the same table.
// - codes 010 to 111 give 220h, 228h, 238h, 2E8h, 338h and 3E8h, each 8 bytes.
// - floppy select bit 4 picks 3F0h-3F5h plus 3F7h when low and the set at 370h when high.
// - printer bits 1:0 pick 378h/778h, 278h/678h or 3BCh-3BEh/7BCh-7BEh, and code 11 is not used.
// - with the 278h window, port 279h only counts as printer for reads.
// - flash cycles are subtractive unless the positive decode switch is 1.
// - flash enable bit 7 claims FFF80000h and FFB80000h blocks plus the 128 KB block below 1 MB.
// - flash enable bits 0 to 6 each claim a pair of 512 KB blocks from FFC00000h and FF800000h upward.
// - the generic window base is bits 15:7, 128-byte aligned, with address bits 31:16 zero.
// - the generic window matches i/o cycles only and spans 128 bytes.
// - generic hits are forwarded only while generic enable bit 0 is set.
// - serial window hits are forwarded only while that port's forward enable is set.
// - printer and floppy hits are forwarded only while their forward enables are set.
`timescale 1ns/1ps
`include "lpc_decode_defs.vh"

module lpc_legacy_range_decoder (
   input wire clk_sys, // core clock, 10 MHz
   input wire reset_n, // async reset, active low
   input wire [7:0] cfgAddr, // configuration byte offset
   input wire cfgWrEn, // config write strobe, one cycle
   input wire [7:0] cfgWrData, // config write byte
   input wire cfgRdEn, // config read strobe, one cycle
   output reg [7:0] cfgRdData, // config read byte, registered
   input wire serialAForwardEnable, // first serial port forward enable
   input wire serialBForwardEnable, // second serial port forward enable
   input wire printerForwardEnable, // printer port forward enable
   input wire floppyForwardEnable, // floppy port forward enable
   input wire positiveDecodeEnable, // 1 = positive flash decode
   input wire hostCycleValid, // host cycle address valid, one cycle
   input wire hostIoCycle, // cycle is i/o
   input wire hostMemCycle, // cycle is memory
   input wire hostRead, // cycle is a read
   input wire [31:0] hostAddr, // host cycle address
   output reg decodeDone, // match results valid, one cycle
   output reg serialAHit, // forwarded first serial hit
   output reg serialBHit, // forwarded second serial hit
   output reg printerHit, // forwarded printer hit
   output reg floppyHit, // forwarded floppy hit
   output reg genericHit, // forwarded generic window hit
   output reg flashHit, // positive flash claim
   output reg forwardToPeriph // any of the hits above
);

   reg [7:0] serialSel_q;
   reg [7:0] floppyPrnSel_q;
   reg [7:0] flashEn_q;
   reg [15:0] generic_q;
   reg [7:0] rdByte_d;
   reg ioLow;
   reg floppyHit_d;
   reg printerHit_d;
   reg genericHit_d;
   reg flashHit_d;
   reg [15:0] floppyBase;
   integer i;
   wire serialAWin;
   wire serialBWin;

   // both serial ports share one table, instantiated per port
   serial_window_match serialAMatch (
      .rangeCode(serialSel_q[`SERIAL_A_MSB:`SERIAL_A_LSB]),
      .ioAddr(hostAddr[15:0]),
      .windowHit(serialAWin)
   );

   serial_window_match serialBMatch (
      .rangeCode(serialSel_q[`SERIAL_B_MSB:`SERIAL_B_LSB]),
      .ioAddr(hostAddr[15:0]),
      .windowHit(serialBWin)
   );

   // one flash pair: upper block and its lower alias, 512 KB each
   function flashPairHit;
      input [31:0] addr;
      input [12:0] pairIdx;
      begin
         flashPairHit = (addr[31:19] == (`FLASH_UPPER_BLK0 + pairIdx)) ||
                        (addr[31:19] == (`FLASH_LOWER_BLK0 + pairIdx));
      end
   endfunction

   // inclusive i/o range compare used by the printer windows
   function inRange;
      input [15:0] addr;
      input [15:0] lo;
      input [15:0] hi;
      begin
         inRange = (addr >= lo) && (addr <= hi);
      end
   endfunction

   // config writes, reserved bits masked so they stay zero
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         serialSel_q <= `RST_SERIAL_SEL;
         floppyPrnSel_q <= `RST_FLOPPY_PRN_SEL;
         flashEn_q <= `RST_FLASH_EN1;
         generic_q <= `RST_GENERIC;
      end else if (cfgWrEn) begin
         case (cfgAddr)
            `OFS_SERIAL_SEL: serialSel_q <= cfgWrData & `MASK_SERIAL_SEL;
            `OFS_FLOPPY_PRN_SEL: floppyPrnSel_q <= cfgWrData & `MASK_FLOPPY_PRN_SEL;
            `OFS_FLASH_EN1: flashEn_q <= cfgWrData & `MASK_FLASH_EN1;
            `OFS_GENERIC_LO: generic_q[7:0] <= cfgWrData & `MASK_GENERIC_LO;
            `OFS_GENERIC_HI: generic_q[15:8] <= cfgWrData & `MASK_GENERIC_HI;
            default: ;
         endcase
      end
   end

   // read mux; unmapped offsets, including E2h, read zero
   always @* begin
      case (cfgAddr)
         `OFS_SERIAL_SEL: rdByte_d = serialSel_q;
         `OFS_FLOPPY_PRN_SEL: rdByte_d = floppyPrnSel_q;
         `OFS_FLASH_EN1: rdByte_d = flashEn_q;
         `OFS_GENERIC_LO: rdByte_d = generic_q[7:0];
         `OFS_GENERIC_HI: rdByte_d = generic_q[15:8];
         default: rdByte_d = 8'h00;
      endcase
   end

   // read data held until the next read strobe
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cfgRdData <= 8'h00;
      end else if (cfgRdEn) begin
         cfgRdData <= rdByte_d;
      end
   end

   // legacy windows are 16-bit i/o; anything with upper bits set is not ours
   always @* begin
      ioLow = hostIoCycle && (hostAddr[31:16] == 16'h0000);
   end

   // floppy: 8-byte block with offset 6 left out
   always @* begin
      if (floppyPrnSel_q[`FLOPPY_SEL_BIT]) begin
         floppyBase = `FLOPPY_SEC_BASE;
      end else begin
         floppyBase = `FLOPPY_PRI_BASE;
      end
      floppyHit_d = ioLow && (hostAddr[15:3] == floppyBase[15:3]) &&
                    (hostAddr[2:0] != `FLOPPY_HOLE_LOW3);
   end

   // printer: reserved code decodes nothing rather than guessing
   always @* begin
      case (floppyPrnSel_q[`PRINTER_MSB:`PRINTER_LSB])
         `PRN_CODE_378: begin
            printerHit_d = (hostAddr[15:3] == `PRN_378_BASE >> 3) ||
                           (hostAddr[15:3] == `PRN_778_BASE >> 3);
         end
         `PRN_CODE_278: begin
            // writes to 279h belong to someone else, so only reads are taken
            printerHit_d = ((hostAddr[15:3] == `PRN_278_BASE >> 3) &&
                            (hostRead || (hostAddr[15:0] != `PRN_READONLY_PORT))) ||
                           (hostAddr[15:3] == `PRN_678_BASE >> 3);
         end
         `PRN_CODE_3BC: begin
            printerHit_d = inRange(hostAddr[15:0], `PRN_3BC_LO, `PRN_3BC_HI) ||
                           inRange(hostAddr[15:0], `PRN_7BC_LO, `PRN_7BC_HI);
         end
         default: printerHit_d = 1'b0;
      endcase
      printerHit_d = printerHit_d && ioLow;
   end

   // generic window: i/o only, 128 bytes from the programmed base
   always @* begin
      genericHit_d = ioLow &&
                     (hostAddr[15:7] == generic_q[`GENERIC_BASE_MSB:`GENERIC_BASE_LSB]) &&
                     generic_q[`GENERIC_EN_BIT];
   end

   // flash: one pair per enable bit, top bit also takes the legacy block
   always @* begin
      flashHit_d = 1'b0;
      for (i = 0; i < `FLASH_PAIRS; i = i + 1) begin
         if (flashEn_q[i] && flashPairHit(hostAddr, i[12:0])) begin
            flashHit_d = 1'b1;
         end
      end
      if (flashEn_q[`FLASH_TOP_BIT] && (hostAddr[31:17] == `FLASH_LEGACY_BLK)) begin
         flashHit_d = 1'b1;
      end
      // with the switch off the cycle is left to subtractive decode
      flashHit_d = flashHit_d && hostMemCycle && positiveDecodeEnable;
   end

   // results registered one cycle after the host cycle, cleared otherwise
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         decodeDone <= 1'b0;
         serialAHit <= 1'b0;
         serialBHit <= 1'b0;
         printerHit <= 1'b0;
         floppyHit <= 1'b0;
         genericHit <= 1'b0;
         flashHit <= 1'b0;
         forwardToPeriph <= 1'b0;
      end else begin
         decodeDone <= hostCycleValid;
         serialAHit <= hostCycleValid && ioLow && serialAWin && serialAForwardEnable;
         serialBHit <= hostCycleValid && ioLow && serialBWin && serialBForwardEnable;
         printerHit <= hostCycleValid && printerHit_d && printerForwardEnable;
         floppyHit <= hostCycleValid && floppyHit_d && floppyForwardEnable;
         genericHit <= hostCycleValid && genericHit_d;
         flashHit <= hostCycleValid && flashHit_d;
         forwardToPeriph <= hostCycleValid &&
                            ((ioLow && serialAWin && serialAForwardEnable) ||
                             (ioLow && serialBWin && serialBForwardEnable) ||
                             (printerHit_d && printerForwardEnable) ||
                             (floppyHit_d && floppyForwardEnable) ||
                             genericHit_d || flashHit_d);
      end
   end

endmodule

// ---- shared/lpc_decode_defs.vh ----
// constants for the legacy range decoder: register offsets, masks, resets, windows
// assumes byte-wide configuration access and 32-bit host addresses
`ifndef LPC_DECODE_DEFS_VH
`define LPC_DECODE_DEFS_VH

// configuration byte offsets
`define OFS_SERIAL_SEL 8'hE0
`define OFS_FLOPPY_PRN_SEL 8'hE1
`define OFS_FLASH_EN1 8'hE3
`define OFS_GENERIC_LO 8'hE4
`define OFS_GENERIC_HI 8'hE5

// reset values
`define RST_SERIAL_SEL 8'h00
`define RST_FLOPPY_PRN_SEL 8'h00
`define RST_FLASH_EN1 8'hFF
`define RST_GENERIC 16'h0000

// writable bit masks, everything else reserved
`define MASK_SERIAL_SEL 8'h77
`define MASK_FLOPPY_PRN_SEL 8'h13
`define MASK_FLASH_EN1 8'hFF
`define MASK_GENERIC_LO 8'h81
`define MASK_GENERIC_HI 8'hFF

// field positions
`define SERIAL_A_MSB 2
`define SERIAL_A_LSB 0
`define SERIAL_B_MSB 6
`define SERIAL_B_LSB 4
`define FLOPPY_SEL_BIT 4
`define PRINTER_MSB 1
`define PRINTER_LSB 0
`define GENERIC_EN_BIT 0
`define GENERIC_BASE_MSB 15
`define GENERIC_BASE_LSB 7
`define FLASH_TOP_BIT 7

// serial window bases, 8 bytes each
`define SER_BASE_0 16'h03F8
`define SER_BASE_1 16'h02F8
`define SER_BASE_2 16'h0220
`define SER_BASE_3 16'h0228
`define SER_BASE_4 16'h0238
`define SER_BASE_5 16'h02E8
`define SER_BASE_6 16'h0338
`define SER_BASE_7 16'h03E8

// floppy windows: base of 8, offset 6 is a hole
`define FLOPPY_PRI_BASE 16'h03F0
`define FLOPPY_SEC_BASE 16'h0370
`define FLOPPY_HOLE_LOW3 3'h6

// printer windows
`define PRN_CODE_378 2'h0
`define PRN_CODE_278 2'h1
`define PRN_CODE_3BC 2'h2
`define PRN_378_BASE 16'h0378
`define PRN_778_BASE 16'h0778
`define PRN_278_BASE 16'h0278
`define PRN_678_BASE 16'h0678
`define PRN_READONLY_PORT 16'h0279
`define PRN_3BC_LO 16'h03BC
`define PRN_3BC_HI 16'h03BE
`define PRN_7BC_LO 16'h07BC
`define PRN_7BC_HI 16'h07BE

// flash ranges, pairs compared on address bits 31:19 (512 KB blocks), legacy block on bits 31:17
`define FLASH_UPPER_BLK0 13'h1FF8
`define FLASH_LOWER_BLK0 13'h1FF0
`define FLASH_LEGACY_BLK 15'h0007
`define FLASH_PAIRS 8

`endif

// ---- design/serial_window_match.v ----
// one serial-port window: 3-bit code selects an 8-byte i/o window, compare against address
// assumes the caller has already checked that address bits 31:16 are zero
`timescale 1ns/1ps
`include "lpc_decode_defs.vh"

module serial_window_match (
   input wire [2:0] rangeCode, // window select code
   input wire [15:0] ioAddr, // low half of the i/o address
   output reg windowHit // address lies in the selected window
);

   reg [15:0] windowBase;

   // table of bases, same for both ports
   always @* begin
      case (rangeCode)
         3'h0: windowBase = `SER_BASE_0;
         3'h1: windowBase = `SER_BASE_1;
         3'h2: windowBase = `SER_BASE_2;
         3'h3: windowBase = `SER_BASE_3;
         3'h4: windowBase = `SER_BASE_4;
         3'h5: windowBase = `SER_BASE_5;
         3'h6: windowBase = `SER_BASE_6;
         default: windowBase = `SER_BASE_7;
      endcase
      windowHit = (ioAddr[15:3] == windowBase[15:3]); // 8-byte window
   end

endmodule

// ---- tb/lpc_legacy_range_decoder_chk.sv ----
// checker: host decode timing and gating
// assumes it is bound to the decoder top
`timescale 1ns/1ps
module lpc_legacy_range_decoder_chk (
   input wire clk_sys, // core clock
   input wire reset_n, // async reset
   input wire [7:0] cfgAddr, // config offset
   input wire cfgRdEn, // read strobe
   input wire [7:0] cfgRdData, // read byte
   input wire serialAForwardEnable, // serial a enable
   input wire serialBForwardEnable, // serial b enable
   input wire printerForwardEnable, // printer enable
   input wire floppyForwardEnable, // floppy enable
   input wire positiveDecodeEnable, // flash decode
   input wire hostCycleValid, // host strobe
   input wire hostIoCycle, // i/o cycle
   input wire hostMemCycle, // memory cycle
   input wire [31:0] hostAddr, // host address
   input wire decodeDone, // results valid
   input wire serialAHit, // serial a hit
   input wire serialBHit, // serial b hit
   input wire printerHit, // printer hit
   input wire floppyHit, // floppy hit
   input wire genericHit, // generic hit
   input wire flashHit, // flash hit
   input wire forwardToPeriph // any hit
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // host request, and one that cannot hit an i/o window
   sequence hostReq; hostCycleValid; endsequence
   sequence memReq; hostCycleValid && !hostIoCycle; endsequence
   done_follows_a: assert property (hostReq |=> decodeDone) else $error("done missing");
   done_only_a: assert property (!hostCycleValid |=> !decodeDone && !forwardToPeriph) else $error("stray done");
   fwd_is_or_a: assert property (forwardToPeriph == (serialAHit || serialBHit || printerHit || floppyHit
      || genericHit || flashHit)) else $error("forward not or of hits");
   serial_gate_a: assert property (serialAHit |-> $past(serialAForwardEnable) && $past(hostIoCycle))
      else $error("serial a hit ungated");
   serial_b_gate_a: assert property (serialBHit |-> $past(serialBForwardEnable) && $past(hostIoCycle))
      else $error("serial b hit ungated");
   printer_gate_a: assert property (printerHit |-> $past(printerForwardEnable)) else $error("printer ungated");
   floppy_gate_a: assert property (floppyHit |-> $past(floppyForwardEnable)) else $error("floppy ungated");
   flash_gate_a: assert property (flashHit |-> $past(positiveDecodeEnable) && $past(hostMemCycle))
      else $error("flash ungated");
   io_upper_a: assert property (genericHit |-> ($past(hostAddr) & 32'hFFFF0000) == 32'h00000000)
      else $error("generic hit above 64k");
   io_only_a: assert property (memReq |=> !(genericHit || serialAHit || serialBHit
      || printerHit || floppyHit)) else $error("i/o hit on memory cycle");
   unmapped_rd_a: assert property (cfgRdEn && cfgAddr == 8'hE2 |=> cfgRdData == 8'h00)
      else $error("unmapped read not zero");
endmodule

// ---- tb/periph_model.sv ----
// peripheral side: counts cycles forwarded to it
// assumes one forward pulse per claimed cycle
`timescale 1ns/1ps
module periph_model (
   input wire clk_sys, // core clock
   input wire forwardToPeriph, // claim pulse
   output reg [31:0] claimCount = 32'h00000000 // claimed cycles
);
   // tally only; the bench compares the total
   always @(posedge clk_sys) if (forwardToPeriph) claimCount <= claimCount + 32'h00000001;
endmodule

// ---- tb/tb_lpc_legacy_range_decoder.sv ----
// bench: config access and host decode of the range decoder
// assumes 10 MHz clock and a lone config master
`timescale 1ns/1ps
module tb_lpc_legacy_range_decoder;
   reg clk_sys, reset_n, cfgWrEn, cfgRdEn, hostCycleValid, hostIoCycle, hostMemCycle, hostRead;
   reg serialAForwardEnable, serialBForwardEnable, printerForwardEnable, floppyForwardEnable;
   reg positiveDecodeEnable;
   reg [7:0] cfgAddr, cfgWrData;
   reg [31:0] hostAddr;
   wire [7:0] cfgRdData;
   wire decodeDone, serialAHit, serialBHit, printerHit, floppyHit, genericHit, flashHit, forwardToPeriph;
   wire [31:0] claimCount;
   integer num_errors = 0, num_checks = 0, numFwd = 0;
   lpc_legacy_range_decoder i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn),
      .cfgWrData(cfgWrData), .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData), .serialAForwardEnable(serialAForwardEnable),
      .serialBForwardEnable(serialBForwardEnable), .printerForwardEnable(printerForwardEnable),
      .floppyForwardEnable(floppyForwardEnable), .positiveDecodeEnable(positiveDecodeEnable),
      .hostCycleValid(hostCycleValid), .hostIoCycle(hostIoCycle), .hostMemCycle(hostMemCycle), .hostRead(hostRead),
      .hostAddr(hostAddr), .decodeDone(decodeDone), .serialAHit(serialAHit), .serialBHit(serialBHit),
      .printerHit(printerHit), .floppyHit(floppyHit), .genericHit(genericHit), .flashHit(flashHit),
      .forwardToPeriph(forwardToPeriph));
   // serial window bases written out from the rules, not taken from the design
   function automatic [15:0] serBase(input integer k);
      case (k)
         0: serBase = 16'h03F8;
         1: serBase = 16'h02F8;
         2: serBase = 16'h0220;
         3: serBase = 16'h0228;
         4: serBase = 16'h0238;
         5: serBase = 16'h02E8;
         6: serBase = 16'h0338;
         default: serBase = 16'h03E8;
      endcase
   endfunction
   // one address in the low and one in the high printer window per code
   function automatic [15:0] prnAddr(input integer p, input hi);
      case (p)
         0: prnAddr = hi ? 16'h0778 : 16'h037F;
         1: prnAddr = hi ? 16'h067F : 16'h0278;
         default: prnAddr = hi ? 16'h07BE : 16'h03BC;
      endcase
   endfunction
   periph_model i_periph (.clk_sys(clk_sys), .forwardToPeriph(forwardToPeriph), .claimCount(claimCount));
   task automatic chk(input string what, input [7:0] exp, input [7:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cfgWr(input [7:0] a, input [7:0] d);
      @(posedge clk_sys);
      cfgAddr <= a;
      cfgWrData <= d;
      cfgWrEn <= 1'b1;
      @(posedge clk_sys);
      cfgWrEn <= 1'b0;
   endtask
   task automatic cfgRd(input [7:0] a, input [7:0] exp);
      @(posedge clk_sys);
      cfgAddr <= a;
      cfgRdEn <= 1'b1;
      @(posedge clk_sys);
      cfgRdEn <= 1'b0;
      #1 chk("cfgRdData", exp, cfgRdData);
   endtask
   // one host cycle; hits packed as serial a, serial b, printer, floppy, generic, flash
   task automatic host(input io, input rd, input [31:0] a, input [5:0] exp);
      @(posedge clk_sys);
      hostCycleValid <= 1'b1;
      hostIoCycle <= io;
      hostMemCycle <= !io;
      hostRead <= rd;
      hostAddr <= a;
      @(posedge clk_sys);
      hostCycleValid <= 1'b0;
      #1 chk("hits", {2'b00, exp}, {2'b00, serialAHit, serialBHit, printerHit, floppyHit, genericHit, flashHit});
      chk("decodeDone", 8'h01, {7'h00, decodeDone});
      if (exp != 6'h00) numFwd++;
   endtask
   task automatic t_regs;
      cfgRd(8'hE0, 8'h00);
      cfgRd(8'hE1, 8'h00);
      cfgRd(8'hE3, 8'hFF);
      cfgRd(8'hE5, 8'h00);
      cfgWr(8'hE0, 8'hFF);
      cfgWr(8'hE1, 8'hFE);
      cfgWr(8'hE4, 8'hFF);
      cfgWr(8'hE2, 8'hFF);
      cfgRd(8'hE0, 8'h77);
      cfgRd(8'hE1, 8'h12);
      cfgRd(8'hE4, 8'h81);
      cfgRd(8'hE2, 8'h00);
   endtask
   task automatic t_serial;
      integer k;
      for (k = 0; k < 8; k++) begin
         cfgWr(8'hE0, {1'b0, ~k[2:0], 1'b0, k[2:0]});
         host(1, 1, serBase(k) + 16'h0007, 6'h20);
         host(1, 0, serBase(7 - k), 6'h10);
      end
      @(posedge clk_sys);
      serialAForwardEnable <= 1'b0;
      serialBForwardEnable <= 1'b0;
      host(1, 0, 32'h000003E8, 6'h00);
      host(1, 0, 32'h000003F8, 6'h00);
      @(posedge clk_sys);
      serialAForwardEnable <= 1'b1;
      serialBForwardEnable <= 1'b1;
   endtask
   task automatic t_prn;
      integer p;
      for (p = 0; p < 3; p++) begin
         cfgWr(8'hE1, p[7:0]);
         host(1, 0, prnAddr(p, 1'b0), 6'h08);
         host(1, 0, prnAddr(p, 1'b1), 6'h08);
      end
      host(1, 0, 32'h000003BF, 6'h00);
      cfgWr(8'hE1, 8'h11);
      host(1, 0, 32'h00000279, 6'h00);
      host(1, 1, 32'h00000279, 6'h08);
      host(1, 0, 32'h00000370, 6'h04);
      cfgWr(8'hE1, 8'h00);
      host(1, 0, 32'h000003F6, 6'h00);
      host(1, 0, 32'h000003F7, 6'h04);
      @(posedge clk_sys);
      floppyForwardEnable <= 1'b0;
      printerForwardEnable <= 1'b0;
      host(1, 0, 32'h000003F7, 6'h00);
      host(1, 0, 32'h00000378, 6'h00);
      @(posedge clk_sys);
      floppyForwardEnable <= 1'b1;
      printerForwardEnable <= 1'b1;
   endtask
   task automatic t_flash;
      integer k;
      host(0, 1, 32'hFFF80000, 6'h00);
      @(posedge clk_sys);
      positiveDecodeEnable <= 1'b1;
      host(0, 1, 32'hFFFFFFFF, 6'h01);
      host(0, 1, 32'hFFB80000, 6'h01);
      host(0, 1, 32'h000E0000, 6'h01);
      host(0, 1, 32'h000DFFFF, 6'h00);
      for (k = 0; k < 7; k++) begin
         host(0, 1, 32'hFFC00000 + k * 32'h80000, 6'h01);
         host(0, 1, 32'hFF87FFFF + k * 32'h80000, 6'h01);
      end
      cfgWr(8'hE3, 8'hFE);
      cfgRd(8'hE3, 8'hFE);
      host(0, 1, 32'hFFC00000, 6'h00);
      host(0, 1, 32'hFFC80000, 6'h01);
      host(1, 1, 32'hFFC80000, 6'h00);
   endtask
   task automatic t_gen;
      cfgWr(8'hE5, 8'h02);
      cfgRd(8'hE5, 8'h02);
      host(1, 0, 32'h00000280, 6'h02);
      host(1, 0, 32'h000002FF, 6'h02);
      host(1, 0, 32'h00000300, 6'h00);
      host(1, 0, 32'h0000027F, 6'h00);
      host(0, 0, 32'h00000280, 6'h00);
      host(1, 0, 32'h00010280, 6'h00);
      cfgWr(8'hE4, 8'h80);
      cfgRd(8'hE4, 8'h80);
      host(1, 0, 32'h00000280, 6'h00);
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // 100 ns clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // all inputs quiet, forward enables on
   initial begin
      {reset_n, cfgWrEn, cfgRdEn, hostCycleValid, hostIoCycle, hostMemCycle, hostRead} = 7'h00;
      {serialAForwardEnable, serialBForwardEnable, printerForwardEnable, floppyForwardEnable} = 4'hF;
      positiveDecodeEnable = 1'b0;
      cfgAddr = 8'h00;
      cfgWrData = 8'h00;
      hostAddr = 32'h00000000;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_regs;
      t_serial;
      t_prn;
      t_flash;
      t_gen;
      @(posedge clk_sys);
      #1 chk("claims", numFwd[7:0], claimCount[7:0]);
      report_and_stop;
   end
   // whole run is a few hundred cycles
   initial begin
      #1000000;
      num_errors++;
      report_and_stop;
   end
endmodule
bind lpc_legacy_range_decoder lpc_legacy_range_decoder_chk i_chk (.clk_sys(clk_sys), .reset_n(reset_n),
   .cfgAddr(cfgAddr), .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData), .serialAForwardEnable(serialAForwardEnable),
   .serialBForwardEnable(serialBForwardEnable), .printerForwardEnable(printerForwardEnable),
   .floppyForwardEnable(floppyForwardEnable), .positiveDecodeEnable(positiveDecodeEnable),
   .hostCycleValid(hostCycleValid), .hostIoCycle(hostIoCycle), .hostMemCycle(hostMemCycle), .hostAddr(hostAddr),
   .decodeDone(decodeDone), .serialAHit(serialAHit), .serialBHit(serialBHit), .printerHit(printerHit),
   .floppyHit(floppyHit), .genericHit(genericHit), .flashHit(flashHit), .forwardToPeriph(forwardToPeriph));
